/* File: verilog/ucpps_consts.svh */
`ifndef UCPPS_CONSTS_SVH
`define UCPPS_CONSTS_SVH

// Register indices on the plain register port
`define UCPPS_ADDR_CTRL      4'h0
`define UCPPS_ADDR_REARM     4'h1
`define UCPPS_ADDR_STATUS    4'h2
`define UCPPS_ADDR_FAULT     4'h3
`define UCPPS_ADDR_CCSTATE   4'h4
`define UCPPS_ADDR_ID        4'h5

// Control register fields, one byte per port (port 2 at +8)
`define UCPPS_CTRL_HV_EN     0
`define UCPPS_CTRL_SOURCE    1
`define UCPPS_CTRL_EXT_MODE  2
`define UCPPS_CTRL_VCONN_EN  3
`define UCPPS_CTRL_DISCH0    4
`define UCPPS_CTRL_DFP       5
`define UCPPS_PORT_STRIDE    8

// Fault bits per port (port 2 at +4)
`define UCPPS_FLT_OCC        0
`define UCPPS_FLT_OCP        1
`define UCPPS_FLT_RCP        2
`define UCPPS_FLT_OVUV       3
`define UCPPS_FLT_STRIDE     4

`define UCPPS_CTRL_RESET     16'h0000
`define UCPPS_ID_VALUE       16'h5A01

// Clamp deglitch, discharge limit and reset pulse
`define UCPPS_CLK_HZ         40000000
`define UCPPS_DEGLITCH_US    16
`define UCPPS_DEGLITCH_CYC   ((`UCPPS_DEGLITCH_US * `UCPPS_CLK_HZ) / 1000000)
`define UCPPS_DISCH0_MS      650
`define UCPPS_DISCH0_CYC     ((`UCPPS_DISCH0_MS * `UCPPS_CLK_HZ) / 1000)
`define UCPPS_HRST_CYC       16

`endif

/* File: verilog/ucpps_pkg.sv */
package ucpps_pkg;

  typedef enum logic [1:0] {
    UCPPS_SUP_OFF,
    UCPPS_SUP_VBUS,
    UCPPS_SUP_MAIN,
    UCPPS_SUP_HRST
  } ucpps_sup_t;

  // Per-pin CC termination seen by the comparators
  typedef enum logic [1:0] {
    UCPPS_CC_OPEN,
    UCPPS_CC_RD,
    UCPPS_CC_RA
  } ucpps_term_t;

  typedef enum logic [2:0] {
    UCPPS_ATT_IDLE,
    UCPPS_ATT_SNK1,
    UCPPS_ATT_SNK2,
    UCPPS_ATT_CBL1,
    UCPPS_ATT_CBL2,
    UCPPS_ATT_ACC
  } ucpps_att_t;

  typedef enum logic [1:0] {
    UCPPS_DIS_IDLE,
    UCPPS_DIS_TO5,
    UCPPS_DIS_TO0
  } ucpps_dis_t;

  typedef struct packed {
    logic        hv_on;
    logic        ext_on;
    logic        vconn_cc1;
    logic        vconn_cc2;
    logic        pull_down;
    logic        latched;
    logic [3:0]  faults;
    logic [15:0] occ_cnt;
    logic [31:0] dis_cnt;
    logic        dis_timeout;
    ucpps_att_t  att;
    ucpps_dis_t  dis;
  } ucpps_port_t;

  typedef struct packed {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    ucpps_sup_t  sup;
    logic [4:0]  hrst_cnt;
    logic        core_en;
    logic        ldo_en;
    logic        hrst;
    logic [15:0] ctrl;
    logic [15:0] rdata;
    ucpps_port_t [1:0] port;
  } ucpps_state_t;

endpackage

/* File: verilog/ucpps_supervisor.sv */
// The implementer's own choices: the register addresses and the address-and-strobe port.
`include "ucpps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ucpps_supervisor
  import ucpps_pkg::*;
#(
  parameter int DEGLITCH_CYC = `UCPPS_DEGLITCH_CYC,
  parameter int DISCH0_CYC   = `UCPPS_DISCH0_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        main_supply_good_i,
  input  wire logic        main_supply_low_i,
  input  wire logic [1:0]  vbus_supply_good_i,
  input  wire logic [1:0]  clamp_active_i,
  input  wire logic [1:0]  trip_current_i,
  input  wire logic [1:0]  reverse_current_i,
  input  wire logic [1:0]  vbus_over_i,
  input  wire logic [1:0]  vbus_under_i,
  input  wire logic [1:0]  vbus_above_safe5_i,
  input  wire logic [1:0]  vbus_above_safe0_i,
  input  wire logic [1:0]  vconn_input_good_i,
  input  wire logic [1:0]  cc1_rd_i,
  input  wire logic [1:0]  cc1_ra_i,
  input  wire logic [1:0]  cc2_rd_i,
  input  wire logic [1:0]  cc2_ra_i,
  input  wire logic [1:0]  cc1_detach_i,
  input  wire logic [1:0]  cc2_detach_i,
  output logic             core_enable_o,
  output logic             vbus_regulator_enable_o,
  output logic             hard_reset_o,
  output logic      [1:0]  high_voltage_path_enable_o,
  output logic      [1:0]  clamp_enable_o,
  output logic      [1:0]  ideal_diode_mode_o,
  output logic      [1:0]  port1_external_path_enable_o,
  output logic      [1:0]  vconn_cc1_enable_o,
  output logic      [1:0]  vconn_cc2_enable_o,
  output logic      [1:0]  vbus_pull_down_o
);

  initial begin
    if (DEGLITCH_CYC < 1 || DEGLITCH_CYC > 65535) begin
      $error("DEGLITCH_CYC out of range");
    end
    if (DISCH0_CYC < 1) begin
      $error("DISCH0_CYC out of range");
    end
  end

  localparam logic [15:0] DEG_LIM = 16'(DEGLITCH_CYC - 1);
  localparam logic [31:0] DIS_LIM = 32'(DISCH0_CYC - 1);

  ucpps_state_t s_reg;
  ucpps_state_t s_next;

  // Comparator levels are asynchronous: two flops before use
  logic [31:0] raw_in;
  logic [31:0] sync1_reg;
  logic [31:0] sync_reg;

  assign raw_in = {vbus_above_safe0_i, cc2_detach_i, cc1_detach_i,
                   cc2_ra_i, cc2_rd_i, cc1_ra_i, cc1_rd_i,
                   vconn_input_good_i, vbus_above_safe5_i, vbus_under_i,
                   vbus_over_i, reverse_current_i, trip_current_i,
                   clamp_active_i, vbus_supply_good_i, main_supply_low_i,
                   main_supply_good_i};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 32'h00000000;
      sync_reg  <= 32'h00000000;
    end else begin
      sync1_reg <= raw_in;
      sync_reg  <= sync1_reg;
    end
  end

  logic       m_good;
  logic       m_low;
  logic [1:0] v_good;
  logic [1:0] clamp;
  logic [1:0] trip;
  logic [1:0] rev;
  logic [1:0] ovr;
  logic [1:0] und;
  logic [1:0] ab5;
  logic [1:0] ab0;
  logic [1:0] vin_good;
  logic [1:0] c1rd;
  logic [1:0] c1ra;
  logic [1:0] c2rd;
  logic [1:0] c2ra;
  logic [1:0] c1det;
  logic [1:0] c2det;

  assign m_good   = sync_reg[0];
  assign m_low    = sync_reg[1];
  assign v_good   = sync_reg[3:2];
  assign clamp    = sync_reg[5:4];
  assign trip     = sync_reg[7:6];
  assign rev      = sync_reg[9:8];
  assign ovr      = sync_reg[11:10];
  assign und      = sync_reg[13:12];
  assign ab5      = sync_reg[15:14];
  assign vin_good = sync_reg[17:16];
  assign c1rd     = sync_reg[19:18];
  assign c1ra     = sync_reg[21:20];
  assign c2rd     = sync_reg[23:22];
  assign c2ra     = sync_reg[25:24];
  assign c1det    = sync_reg[27:26];
  assign c2det    = sync_reg[29:28];
  assign ab0      = sync_reg[31:30];

  always_comb begin
    logic [7:0] pc;
    logic       src;
    logic       wr_rearm;
    logic       fault;
    logic       attached;
    logic       cable_ok;
    s_next   = s_reg;
    pc       = 8'h00;
    src      = 1'b0;
    wr_rearm = wr_i && (addr_i == `UCPPS_ADDR_REARM);
    fault    = 1'b0;
    attached = 1'b0;
    cable_ok = 1'b0;
    s_next.sync1 = 2'b00;
    s_next.sync2 = 2'b00;

    if (wr_i && addr_i == `UCPPS_ADDR_CTRL) begin
      s_next.ctrl = wdata_i;
    end

    s_next.hrst = 1'b0;
    case (s_reg.sup)
      UCPPS_SUP_OFF: begin
        s_next.core_en = 1'b0;
        s_next.ldo_en  = 1'b0;
        if (m_good) begin
          s_next.sup     = UCPPS_SUP_MAIN;
          s_next.core_en = 1'b1;
        end else if (|v_good) begin
          s_next.sup     = UCPPS_SUP_VBUS;
          s_next.ldo_en  = 1'b1;
          s_next.core_en = 1'b1;
        end
      end
      UCPPS_SUP_VBUS: begin
        if (m_good) begin
          s_next.sup    = UCPPS_SUP_MAIN;
          s_next.ldo_en = 1'b0;
        end else if (!(|v_good)) begin
          s_next.sup     = UCPPS_SUP_OFF;
          s_next.core_en = 1'b0;
          s_next.ldo_en  = 1'b0;
        end
      end
      UCPPS_SUP_MAIN: begin
        s_next.ldo_en = 1'b0;
        if (m_low && (|v_good)) begin
          s_next.sup      = UCPPS_SUP_HRST;
          s_next.hrst     = 1'b1;
          s_next.hrst_cnt = 5'h00;
          s_next.core_en  = 1'b0;
        end else if (m_low) begin
          s_next.sup     = UCPPS_SUP_OFF;
          s_next.core_en = 1'b0;
        end
      end
      UCPPS_SUP_HRST: begin
        s_next.hrst     = 1'b1;
        s_next.hrst_cnt = s_reg.hrst_cnt + 5'h01;
        if (s_reg.hrst_cnt == 5'(`UCPPS_HRST_CYC - 1)) begin
          s_next.hrst = 1'b0;
          s_next.sup  = UCPPS_SUP_OFF;
        end
      end
      default: s_next.sup = UCPPS_SUP_OFF;
    endcase

    for (int p = 0; p < 2; p++) begin
      pc  = s_reg.ctrl[p*`UCPPS_PORT_STRIDE +: 8];
      src = pc[`UCPPS_CTRL_SOURCE];
      s_next.port[p].faults = 4'h0;

      if (s_reg.port[p].hv_on && src && clamp[p]) begin
        if (s_reg.port[p].occ_cnt == DEG_LIM) begin
          s_next.port[p].faults[`UCPPS_FLT_OCC] = 1'b1;
        end else begin
          s_next.port[p].occ_cnt = s_reg.port[p].occ_cnt + 16'h0001;
        end
      end else begin
        s_next.port[p].occ_cnt = 16'h0000;
      end
      s_next.port[p].faults[`UCPPS_FLT_OCP] = trip[p];
      s_next.port[p].faults[`UCPPS_FLT_RCP] = rev[p];
      s_next.port[p].faults[`UCPPS_FLT_OVUV] = ovr[p] | und[p];
      fault = s_next.port[p].faults[`UCPPS_FLT_OCC] | trip[p] | rev[p];

      if (fault) begin
        s_next.port[p].latched = 1'b1;
      end else if (wr_rearm && wdata_i[p]) begin
        s_next.port[p].latched = 1'b0;
      end

      case (s_reg.port[p].att)
        UCPPS_ATT_IDLE: begin
          if (c1rd[p] && c2rd[p] || c1ra[p] && c2ra[p])
            s_next.port[p].att = UCPPS_ATT_ACC;
          else if (c1ra[p] && c2rd[p])
            s_next.port[p].att = UCPPS_ATT_CBL1;
          else if (c2ra[p] && c1rd[p])
            s_next.port[p].att = UCPPS_ATT_CBL2;
          else if (c1rd[p] && !c2ra[p])
            s_next.port[p].att = UCPPS_ATT_SNK1;
          else if (c2rd[p] && !c1ra[p])
            s_next.port[p].att = UCPPS_ATT_SNK2;
        end
        UCPPS_ATT_SNK1, UCPPS_ATT_CBL2: begin
          if (c1det[p]) s_next.port[p].att = UCPPS_ATT_IDLE;
        end
        UCPPS_ATT_SNK2, UCPPS_ATT_CBL1: begin
          if (c2det[p]) s_next.port[p].att = UCPPS_ATT_IDLE;
        end
        UCPPS_ATT_ACC: begin
          if (c1det[p] || c2det[p]) s_next.port[p].att = UCPPS_ATT_IDLE;
        end
        default: s_next.port[p].att = UCPPS_ATT_IDLE;
      endcase
      if (!pc[`UCPPS_CTRL_DFP]) begin
        s_next.port[p].att = UCPPS_ATT_IDLE;
      end
      attached = (s_reg.port[p].att != UCPPS_ATT_IDLE) &&
                 (s_reg.port[p].att != UCPPS_ATT_ACC);

      s_next.port[p].hv_on = pc[`UCPPS_CTRL_HV_EN] && !s_next.port[p].latched
        && !(ovr[p] | und[p]) && s_reg.core_en
        && (!src || !pc[`UCPPS_CTRL_DFP] || attached);

      s_next.port[p].ext_on = pc[`UCPPS_CTRL_EXT_MODE] && !(ovr[p] | und[p])
        && s_reg.core_en;

      cable_ok = pc[`UCPPS_CTRL_VCONN_EN] && s_reg.core_en;
      s_next.port[p].vconn_cc1 = cable_ok && s_reg.port[p].att == UCPPS_ATT_CBL1
        && (s_reg.port[p].vconn_cc1 || vin_good[p]);
      s_next.port[p].vconn_cc2 = cable_ok && s_reg.port[p].att == UCPPS_ATT_CBL2
        && (s_reg.port[p].vconn_cc2 || vin_good[p]);

      case (s_reg.port[p].dis)
        UCPPS_DIS_IDLE: begin
          s_next.port[p].pull_down = 1'b0;
          if (!s_reg.port[p].hv_on && pc[`UCPPS_CTRL_DISCH0] && ab0[p]) begin
            s_next.port[p].dis         = UCPPS_DIS_TO0;
            s_next.port[p].dis_cnt     = 32'h00000000;
            s_next.port[p].dis_timeout = 1'b0;
            s_next.port[p].pull_down   = 1'b1;
          end else if (!s_reg.port[p].hv_on && ab5[p]) begin
            s_next.port[p].dis       = UCPPS_DIS_TO5;
            s_next.port[p].pull_down = 1'b1;
          end
        end
        UCPPS_DIS_TO5: begin
          if (s_reg.port[p].hv_on || !ab5[p]) begin
            s_next.port[p].dis       = UCPPS_DIS_IDLE;
            s_next.port[p].pull_down = 1'b0;
          end
        end
        UCPPS_DIS_TO0: begin
          if (s_reg.port[p].dis_cnt != DIS_LIM) begin
            s_next.port[p].dis_cnt = s_reg.port[p].dis_cnt + 32'h00000001;
          end else begin
            s_next.port[p].dis_timeout = 1'b1;
          end
          if (s_reg.port[p].hv_on || !ab0[p]) begin
            s_next.port[p].dis       = UCPPS_DIS_IDLE;
            s_next.port[p].pull_down = 1'b0;
          end
        end
        default: s_next.port[p].dis = UCPPS_DIS_IDLE;
      endcase
    end

    s_next.rdata = 16'h0000;
    if (rd_i) begin
      if (addr_i == `UCPPS_ADDR_CTRL) begin
        s_next.rdata = s_reg.ctrl;
      end else if (addr_i == `UCPPS_ADDR_STATUS) begin
        s_next.rdata = {4'h0, s_reg.port[1].dis_timeout,
          s_reg.port[0].dis_timeout, s_reg.port[1].latched,
          s_reg.port[0].latched, s_reg.port[1].hv_on, s_reg.port[0].hv_on,
          s_reg.ldo_en, s_reg.core_en, 2'(s_reg.sup), m_good, |v_good};
      end else if (addr_i == `UCPPS_ADDR_FAULT) begin
        s_next.rdata = {8'h00, s_reg.port[1].faults, s_reg.port[0].faults};
      end else if (addr_i == `UCPPS_ADDR_CCSTATE) begin
        s_next.rdata = {9'h000, 3'(s_reg.port[1].att), 1'b0,
          3'(s_reg.port[0].att)};
      end else if (addr_i == `UCPPS_ADDR_ID) begin
        s_next.rdata = `UCPPS_ID_VALUE;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.ctrl <= `UCPPS_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o                 = s_reg.rdata;
  assign core_enable_o           = s_reg.core_en;
  assign vbus_regulator_enable_o = s_reg.ldo_en;
  assign hard_reset_o            = s_reg.hrst;

  for (genvar g = 0; g < 2; g++) begin : g_port
    assign high_voltage_path_enable_o[g]   = s_reg.port[g].hv_on;
    assign clamp_enable_o[g]     = s_reg.port[g].hv_on &&
                                   s_reg.ctrl[g*8 + `UCPPS_CTRL_SOURCE];
    assign ideal_diode_mode_o[g] = !s_reg.ctrl[g*8 + `UCPPS_CTRL_SOURCE];
    assign port1_external_path_enable_o[g] = s_reg.port[g].ext_on;
    assign vconn_cc1_enable_o[g] = s_reg.port[g].vconn_cc1;
    assign vconn_cc2_enable_o[g] = s_reg.port[g].vconn_cc2;
    assign vbus_pull_down_o[g]   = s_reg.port[g].pull_down;
  end

endmodule

`default_nettype wire

/* File: sim/ucpps_supervisor_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ucpps_supervisor_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       main_supply_good_i,
  input wire logic [1:0] vbus_supply_good_i,
  input wire logic [1:0] trip_current_i,
  input wire logic [1:0] vbus_over_i,
  input wire logic [1:0] vbus_under_i,
  input wire logic       vbus_regulator_enable_o,
  input wire logic       core_enable_o,
  input wire logic       hard_reset_o,
  input wire logic [1:0] high_voltage_path_enable_o,
  input wire logic [1:0] clamp_enable_o,
  input wire logic [1:0] ideal_diode_mode_o,
  input wire logic [1:0] port1_external_path_enable_o,
  input wire logic [1:0] vbus_pull_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_core_off;
    (!main_supply_good_i && vbus_supply_good_i == 2'h0) [*4] |-> !core_enable_o;
  endproperty
  a_core_off: assert property (p_core_off) else $error("core on, no supply");
  property p_main_pref;
    main_supply_good_i [*8] |-> !vbus_regulator_enable_o;
  endproperty
  a_main_pref: assert property (p_main_pref) else $error("regulator on");
  property p_hrst_len;
    $rose(hard_reset_o) |-> hard_reset_o [*8];
  endproperty
  a_hrst_len: assert property (p_hrst_len) else $error("reset pulse short");
  property p_trip_off;
    $rose(trip_current_i[0]) |-> ##[1:5] !high_voltage_path_enable_o[0];
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip not latched");
  property p_ov_off;
    vbus_over_i[0] [*4] |-> !high_voltage_path_enable_o[0];
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("path on in OV");
  property p_ext_off;
    vbus_under_i[1] [*4] |-> !port1_external_path_enable_o[1];
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ext on in UV");
  property p_clamp_src;
    clamp_enable_o[0] |-> !ideal_diode_mode_o[0];
  endproperty
  a_clamp_src: assert property (p_clamp_src) else $error("clamp in sink");
  property p_pd_off;
    high_voltage_path_enable_o[0] [*2] |-> !vbus_pull_down_o[0];
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("pull-down with path");
endmodule

bind ucpps_supervisor ucpps_supervisor_monitor u_monitor (
  .clk_i, .rst_i, .main_supply_good_i, .vbus_supply_good_i, .trip_current_i,
  .vbus_over_i, .vbus_under_i, .vbus_regulator_enable_o, .core_enable_o,
  .hard_reset_o, .high_voltage_path_enable_o, .clamp_enable_o,
  .ideal_diode_mode_o, .port1_external_path_enable_o, .vbus_pull_down_o
);
`default_nettype wire

/* File: sim/ucpps_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ucpps_partner #(
  parameter int STEP = 20
) (
  input  wire logic       clk_i,
  input  wire logic [5:0] att_i,
  input  wire logic [1:0] hv_i,
  input  wire logic [1:0] pd_i,
  output logic      [1:0] rd1_o,
  output logic      [1:0] ra1_o,
  output logic      [1:0] rd2_o,
  output logic      [1:0] ra2_o,
  output logic      [1:0] det1_o,
  output logic      [1:0] det2_o,
  output logic      [1:0] above5_o,
  output logic      [1:0] above0_o
);
  logic [1:0] lvl_reg [2] = '{2'h0, 2'h0};
  int         cnt_reg [2] = '{0, 0};
  logic [2:0] a;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      a = att_i[3*p+:3];
      rd1_o[p] = (a == 3'h1) || (a == 3'h4);
      rd2_o[p] = (a == 3'h2) || (a == 3'h3);
      ra1_o[p] = a == 3'h3;
      ra2_o[p] = a == 3'h4;
      // An unterminated pin floats above every detach level
      det1_o[p] = !(rd1_o[p] || ra1_o[p]);
      det2_o[p] = !(rd2_o[p] || ra2_o[p]);
      above5_o[p] = lvl_reg[p] == 2'h2;
      above0_o[p] = lvl_reg[p] != 2'h0;
    end
  end

  // Bulk capacitance: one level step per STEP+1 cycles of pull-down
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (hv_i[p]) begin
        lvl_reg[p] <= 2'h2;
        cnt_reg[p] <= 0;
      end else if (pd_i[p] && lvl_reg[p] != 2'h0) begin
        cnt_reg[p] <= (cnt_reg[p] == STEP) ? 0 : cnt_reg[p] + 1;
        if (cnt_reg[p] == STEP) lvl_reg[p] <= lvl_reg[p] - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/ucpps_supervisor_bench.sv */
`include "ucpps_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ucpps_supervisor_bench;
  logic        clk_i, rst_i, wr_i, rd_i, main_supply_good_i, main_supply_low_i;
  logic        core_enable_o, vbus_regulator_enable_o, hard_reset_o;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [1:0]  vbus_supply_good_i, clamp_active_i, trip_current_i;
  logic [1:0]  reverse_current_i, vbus_over_i, vbus_under_i, vconn_input_good_i;
  logic [1:0]  cc1_rd_i, cc1_ra_i, cc2_rd_i, cc2_ra_i, cc1_detach_i, cc2_detach_i;
  logic [1:0]  vbus_above_safe5_i, vbus_above_safe0_i, vbus_pull_down_o;
  logic [1:0]  high_voltage_path_enable_o, clamp_enable_o, ideal_diode_mode_o;
  logic [1:0]  port1_external_path_enable_o, vconn_cc1_enable_o;
  logic [1:0]  vconn_cc2_enable_o;
  logic [5:0]  att;
  int          miscompares, comparisons, cycles;
  // Nibbles: attach code, input good, {path, vconn pin 1, pin 2}, state
  logic [15:0] rows [11] = '{16'h0100, 16'h1141, 16'h0100, 16'h2142,
    16'h0100, 16'h3043, 16'h3163, 16'h3063, 16'h0100, 16'h4154, 16'h0100};

  ucpps_supervisor #(.DEGLITCH_CYC(4), .DISCH0_CYC(50)) dut (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .main_supply_good_i, .main_supply_low_i, .vbus_supply_good_i,
    .clamp_active_i, .trip_current_i, .reverse_current_i, .vbus_over_i,
    .vbus_under_i, .vbus_above_safe5_i, .vbus_above_safe0_i,
    .vconn_input_good_i, .cc1_rd_i, .cc1_ra_i, .cc2_rd_i, .cc2_ra_i,
    .cc1_detach_i, .cc2_detach_i, .core_enable_o, .vbus_regulator_enable_o,
    .hard_reset_o, .high_voltage_path_enable_o, .clamp_enable_o,
    .ideal_diode_mode_o, .port1_external_path_enable_o, .vconn_cc1_enable_o,
    .vconn_cc2_enable_o, .vbus_pull_down_o
  );

  ucpps_partner #(.STEP(20)) partner (
    .clk_i   (clk_i),
    .att_i   (att),
    .hv_i    (high_voltage_path_enable_o),
    .pd_i    (vbus_pull_down_o),
    .rd1_o   (cc1_rd_i),
    .ra1_o   (cc1_ra_i),
    .rd2_o   (cc2_rd_i),
    .ra2_o   (cc2_ra_i),
    .det1_o  (cc1_detach_i),
    .det2_o  (cc2_detach_i),
    .above5_o(vbus_above_safe5_i),
    .above0_o(vbus_above_safe0_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic final_report;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    d = rdata_o;
    tick(1);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [15:0] m,
                         input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    cmp(d & m, exp);
  endtask

  initial begin
    {rst_i, wr_i, rd_i, main_supply_good_i, main_supply_low_i} = 5'h10;
    {addr_i, wdata_i, att} = 26'h0000000;
    {vbus_supply_good_i, clamp_active_i, trip_current_i} = 6'h00;
    {reverse_current_i, vbus_over_i, vbus_under_i} = 6'h00;
    vconn_input_good_i = 2'h3;
    tick(8);
    rst_i <= 1'b0;
    tick(4);
    chk_pin(core_enable_o, 1'b0);
    vbus_supply_good_i <= 2'h1;
    tick(6);
    chk_pin(core_enable_o, 1'b1);
    chk_pin(vbus_regulator_enable_o, 1'b1);
    vbus_supply_good_i <= 2'h3;
    main_supply_good_i <= 1'b1;
    repeat (12) begin
      tick(1);
      chk_pin(core_enable_o, 1'b1);
    end
    chk_pin(vbus_regulator_enable_o, 1'b0);
    chk_reg(`UCPPS_ADDR_STATUS, 16'h000C, 16'h0008);
    chk_reg(`UCPPS_ADDR_ID, 16'hFFFF, `UCPPS_ID_VALUE);
    chk_reg(4'hF, 16'hFFFF, 16'h0000);
    chk_reg(`UCPPS_ADDR_CTRL, 16'hFFFF, `UCPPS_CTRL_RESET);
    wr(`UCPPS_ADDR_CTRL, 16'h002B);
    chk_reg(`UCPPS_ADDR_CTRL, 16'hFFFF, 16'h002B);
    foreach (rows[i]) begin
      att[2:0] <= rows[i][14:12];
      vconn_input_good_i <= {1'b1, rows[i][8]};
      tick(10);
      chk_pin(high_voltage_path_enable_o[0], rows[i][6]);
      chk_pin(vconn_cc1_enable_o[0], rows[i][5]);
      chk_pin(vconn_cc2_enable_o[0], rows[i][4]);
      chk_reg(`UCPPS_ADDR_CCSTATE, 16'h0007, {13'h0000, rows[i][2:0]});
    end
    att <= 6'h01;
    tick(10);
    chk_pin(clamp_enable_o[0], 1'b1);
    chk_pin(ideal_diode_mode_o[0], 1'b0);
    for (int k = 0; k < 3; k++) begin
      clamp_active_i[0] <= (k == 0);
      trip_current_i[0] <= (k == 1);
      reverse_current_i[0] <= (k == 2);
      tick(12);
      chk_pin(high_voltage_path_enable_o[0], 1'b0);
      // Clamp fault is live and clears once the path is off
      chk_reg(`UCPPS_ADDR_FAULT, 16'h0001 << k,
              (k == 0) ? 16'h0000 : 16'h0001 << k);
      chk_reg(`UCPPS_ADDR_STATUS, 16'h0100, 16'h0100);
      {clamp_active_i[0], trip_current_i[0], reverse_current_i[0]} <= 3'h0;
      tick(8);
      if (k < 2) chk_pin(high_voltage_path_enable_o[0], 1'b0);
      wr(`UCPPS_ADDR_REARM, 16'h0001);
      tick(10);
      chk_pin(high_voltage_path_enable_o[0], 1'b1);
    end
    // Port one as sink; port two drives an external path
    wr(`UCPPS_ADDR_CTRL, 16'h0529);
    tick(10);
    chk_pin(clamp_enable_o[0], 1'b0);
    chk_pin(ideal_diode_mode_o[0], 1'b1);
    chk_pin(high_voltage_path_enable_o[0], 1'b1);
    chk_pin(port1_external_path_enable_o[1], 1'b1);
    vbus_under_i[1] <= 1'b1;
    vbus_over_i[0] <= 1'b1;
    tick(8);
    chk_pin(port1_external_path_enable_o[1], 1'b0);
    chk_pin(high_voltage_path_enable_o[0], 1'b0);
    {vbus_under_i[1], vbus_over_i[0]} <= 2'h0;
    wr(`UCPPS_ADDR_REARM, 16'h0001);
    tick(1);
    wr(`UCPPS_ADDR_CTRL, 16'h002B);
    tick(20);
    wr(`UCPPS_ADDR_CTRL, 16'h002A);
    tick(6);
    chk_pin(vbus_pull_down_o[0], 1'b1);
    tick(60);
    chk_pin(vbus_pull_down_o[0], 1'b0);
    chk_pin(vbus_above_safe0_i[0], 1'b1);
    wr(`UCPPS_ADDR_CTRL, 16'h003A);
    tick(6);
    chk_pin(vbus_pull_down_o[0], 1'b1);
    tick(60);
    chk_pin(vbus_pull_down_o[0], 1'b0);
    chk_pin(vbus_above_safe0_i[0], 1'b0);
    chk_reg(`UCPPS_ADDR_STATUS, 16'h0400, 16'h0000);
    main_supply_good_i <= 1'b0;
    main_supply_low_i <= 1'b1;
    tick(6);
    chk_pin(hard_reset_o, 1'b1);
    tick(24);
    chk_pin(hard_reset_o, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
